// [design/smec_pkg.sv]
// Package with the constants and types of the sleep mode entry control.
package smec_pkg;
   // ----------------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------------
   localparam int          SMEC_AW          = 4;
   localparam int          SMEC_DW          = 8;
   localparam logic [3:0]  SMEC_OFS_CTRL    = 4'h0;
   localparam logic [3:0]  SMEC_OFS_STATUS  = 4'h1;
   localparam logic [3:0]  SMEC_OFS_WDT_LO  = 4'h2;
   localparam logic [3:0]  SMEC_OFS_WDT_HI  = 4'h3;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int          SMEC_CTRL_IDLE   = 0;
   localparam int          SMEC_CTRL_WSLEEP = 1;
   localparam int          SMEC_CTRL_WEN    = 2;
   localparam int          SMEC_CTRL_ADCRC  = 3;
   localparam int          SMEC_ST_PD       = 0;
   localparam int          SMEC_ST_TO       = 1;
   localparam int          SMEC_ST_INVALID  = 2;
   localparam int          SMEC_ST_MODE     = 4;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [3:0]  SMEC_CTRL_RST    = 4'h0;
   localparam logic        SMEC_PD_RST      = 1'b1;
   localparam logic        SMEC_TO_RST      = 1'b1;

   // ----------------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------------
   localparam int          SMEC_WDT_W       = 16;
   localparam int          SMEC_WDT_PERIOD  = 65535;

   typedef enum logic [1:0] {
      SMEC_RUN,
      SMEC_IDLE,
      SMEC_SLEEP
   } smec_mode_t;
endpackage

// [design/smec_wdt_if.sv]
// Interface joining the sleep controller to its watchdog counter.
`timescale 1ns/1ps
interface smec_wdt_if #(
   parameter int W = 16
);
   logic         clear;
   logic         run;
   logic [W-1:0] count;
   logic         timeout;

   modport ctl (output clear, output run, input count, input timeout);
   modport wdt (input clear, input run, output count, output timeout);
endinterface

// [design/smec_wdt.sv]
// Wrapping watchdog counter, cleared on command and counting while enabled.
`timescale 1ns/1ps
module smec_wdt #(
   parameter int W      = 16,
   parameter int PERIOD = 65535
) (
   input  wire logic clock,
   input  wire logic rst_n,
   smec_wdt_if.wdt   wif
);
   logic [W-1:0] cnt_q;
   logic         to_q;
   logic         wrap;

   generate
      if (PERIOD < 2 || PERIOD > (2**W)) begin : g_bad
         $error("Watchdog period does not fit the counter width.");
      end
   endgenerate

   assign wrap = (cnt_q == W'(PERIOD - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         to_q  <= 1'b0;
      end else begin
         to_q <= 1'b0;
         if (wif.clear) begin
            cnt_q <= '0;
         end else if (wif.run) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            to_q  <= wrap;
         end
      end
   end

   assign wif.count   = cnt_q;
   assign wif.timeout = to_q;
endmodule

// [design/smec_top.sv]
// Sleep and idle entry control with watchdog, flags, clocks, ADC and pin hold.
`timescale 1ns/1ps
// How it works
// - Sleep instruction with idle select clear enters full sleep.
// - Sleep instruction with idle select set enters idle instead.
// - Entry clears the watchdog; it keeps counting if enabled in sleep.
// - Entry clears the power-down flag.
// - Entry sets the timeout flag.
// - Low, high frequency internal and secondary oscillators keep running.
// - RC-clocked conversion continues; system-clocked conversion is abandoned on full sleep entry, result invalid.
// - Pins hold their pre-sleep drive, except active asynchronous peripherals.
// - Reset sources other than the watchdog act the same asleep.
module smec_top
   import smec_pkg::*;
#(
   parameter int IO_W       = 8,
   parameter int WDT_PERIOD = SMEC_WDT_PERIOD
) (
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic [SMEC_AW-1:0]  addr,
   input  wire logic [SMEC_DW-1:0]  wdata,
   input  wire logic                wr_en,
   input  wire logic                rd_en,
   output logic [SMEC_DW-1:0]       rdata_q,
   input  wire logic                sleep_exec,
   input  wire logic                wake_pin,
   input  wire logic                ext_reset_pin,
   input  wire logic                adc_busy,
   input  wire logic [IO_W-1:0]     core_io_out,
   input  wire logic [IO_W-1:0]     core_io_oe,
   input  wire logic [IO_W-1:0]     async_io_en,
   input  wire logic [IO_W-1:0]     async_io_out,
   output logic [IO_W-1:0]          io_out_q,
   output logic [IO_W-1:0]          io_oe_q,
   output logic                     cpu_clk_en_q,
   output logic                     sys_clk_en_q,
   output logic                     low_freq_internal_osc_en_q,
   output logic                     high_freq_internal_osc_en_q,
   output logic                     secondary_osc_en_q,
   output logic                     adc_abort_q,
   output logic                     wdt_reset_q,
   output logic                     ext_reset_req_q,
   output smec_mode_t               mode_q
);
   // ----------------------------------------------------------------------
   // Checks and synchronisers
   // ----------------------------------------------------------------------
   generate
      if (IO_W < 1 || IO_W > 32) begin : g_bad
         $error("IO_W must lie between 1 and 32.");
      end
   endgenerate

   logic [1:0] wake_s_q;
   logic [1:0] rst_s_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wake_s_q <= 2'h0;
         rst_s_q  <= 2'h0;
      end else begin
         wake_s_q <= {wake_s_q[0], wake_pin};
         rst_s_q  <= {rst_s_q[0], ext_reset_pin};
      end
   end

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   function automatic logic hit(input logic [SMEC_AW-1:0] a, input logic [SMEC_AW-1:0] ofs);
      hit = (a == ofs);
   endfunction

   logic [3:0]  ctrl_q;
   logic        pd_q;
   logic        to_q;
   logic        invalid_q;
   logic        wr_ctrl;
   logic        wr_status;
   logic        idle_select_bit;
   logic        wdt_sleep_run;
   logic        wdt_enable;
   logic        adc_rc_sel;

   assign wr_ctrl         = wr_en && hit(addr, SMEC_OFS_CTRL);
   assign wr_status       = wr_en && hit(addr, SMEC_OFS_STATUS);
   assign idle_select_bit = ctrl_q[SMEC_CTRL_IDLE];
   assign wdt_sleep_run   = ctrl_q[SMEC_CTRL_WSLEEP];
   assign wdt_enable      = ctrl_q[SMEC_CTRL_WEN];
   assign adc_rc_sel      = ctrl_q[SMEC_CTRL_ADCRC];

   // ----------------------------------------------------------------------
   // Mode sequencing
   // ----------------------------------------------------------------------
   smec_mode_t mode_d;
   logic       sleep_go;
   logic       full_go;
   logic       abandon;
   logic       asleep;

   assign sleep_go = sleep_exec && (mode_q == SMEC_RUN);
   assign full_go  = sleep_go && !idle_select_bit;
   assign abandon  = full_go && adc_busy && !adc_rc_sel;
   assign asleep   = (mode_q != SMEC_RUN);

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         SMEC_RUN: begin
            if (sleep_go) begin
               mode_d = idle_select_bit ? SMEC_IDLE : SMEC_SLEEP;
            end
         end
         SMEC_IDLE,
         SMEC_SLEEP: begin
            if (wake_s_q[1]) begin
               mode_d = SMEC_RUN;
            end
         end
         default: mode_d = SMEC_RUN;
      endcase
   end

   // ----------------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------------
   smec_wdt_if #(.W(SMEC_WDT_W)) wif ();

   // clear on entry, run in sleep if enabled
   assign wif.clear = sleep_go;
   assign wif.run   = wdt_enable && (!asleep || wdt_sleep_run);

   smec_wdt #(
      .W      (SMEC_WDT_W),
      .PERIOD (WDT_PERIOD)
   ) u_wdt (
      .clock (clock),
      .rst_n (rst_n),
      .wif   (wif)
   );

   // ----------------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= SMEC_RUN;
         ctrl_q <= SMEC_CTRL_RST;
      end else begin
         mode_q <= mode_d;
         if (wr_ctrl) begin
            ctrl_q <= wdata[3:0];
         end
      end
   end

   // Hardware events beat a software write in the same cycle.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pd_q      <= SMEC_PD_RST;
         to_q      <= SMEC_TO_RST;
         invalid_q <= 1'b0;
      end else begin
         if (sleep_go) begin
            pd_q <= 1'b0;
         end else if (wr_status && wdata[SMEC_ST_PD]) begin
            pd_q <= 1'b1;
         end
         if (sleep_go) begin
            to_q <= 1'b1;
         end else if (wif.timeout) begin
            to_q <= 1'b0;
         end else if (wr_status && wdata[SMEC_ST_TO]) begin
            to_q <= 1'b1;
         end
         if (abandon) begin
            invalid_q <= 1'b1;
         end else if (wr_status && wdata[SMEC_ST_INVALID]) begin
            invalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Clocks, oscillators, pins and resets
   // ----------------------------------------------------------------------
   logic [IO_W-1:0] io_out_d;
   logic [IO_W-1:0] io_oe_d;
   logic            hold_d;

   // hold pins unless an async peripheral drives them
   assign hold_d   = (mode_d != SMEC_RUN);
   assign io_out_d = hold_d ? ((async_io_en & async_io_out) | (~async_io_en & io_out_q)) : core_io_out;
   assign io_oe_d  = hold_d ? (async_io_en | io_oe_q) : core_io_oe;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clk_en_q                <= 1'b1;
         sys_clk_en_q                <= 1'b1;
         low_freq_internal_osc_en_q  <= 1'b1;
         high_freq_internal_osc_en_q <= 1'b1;
         secondary_osc_en_q          <= 1'b1;
         adc_abort_q                 <= 1'b0;
         wdt_reset_q                 <= 1'b0;
         ext_reset_req_q             <= 1'b0;
         io_out_q                    <= '0;
         io_oe_q                     <= '0;
      end else begin
         cpu_clk_en_q                <= (mode_d == SMEC_RUN);
         sys_clk_en_q                <= (mode_d != SMEC_SLEEP);
         low_freq_internal_osc_en_q  <= 1'b1;
         high_freq_internal_osc_en_q <= 1'b1;
         secondary_osc_en_q          <= 1'b1;
         adc_abort_q                 <= abandon;
         wdt_reset_q                 <= wif.timeout;
         ext_reset_req_q             <= rst_s_q[1];
         io_out_q                    <= io_out_d;
         io_oe_q                     <= io_oe_d;
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   logic [SMEC_DW-1:0] rd_mux;
   logic [SMEC_DW-1:0] status_val;

   assign status_val = SMEC_DW'({mode_q, 1'b0, invalid_q, to_q, pd_q});
   assign rd_mux = hit(addr, SMEC_OFS_CTRL)   ? SMEC_DW'(ctrl_q) :
                   hit(addr, SMEC_OFS_STATUS) ? status_val :
                   hit(addr, SMEC_OFS_WDT_LO) ? wif.count[7:0] :
                   hit(addr, SMEC_OFS_WDT_HI) ? wif.count[15:8] : 8'h00;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_en ? rd_mux : 8'h00;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   property p_full_entry;
      @(posedge clock) disable iff (!rst_n) full_go |=> mode_q == SMEC_SLEEP && !cpu_clk_en_q;
   endproperty
   a_full_entry: assert property (p_full_entry) else $error("Sleep not entered.");

   property p_idle_entry;
      @(posedge clock) disable iff (!rst_n)
         sleep_go && idle_select_bit |=> mode_q == SMEC_IDLE && sys_clk_en_q;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("Idle not entered.");

   property p_wdt_clear;
      @(posedge clock) disable iff (!rst_n) sleep_go |=> wif.count == '0;
   endproperty
   a_wdt_clear: assert property (p_wdt_clear) else $error("Watchdog not cleared.");

   property p_pd_clear;
      @(posedge clock) disable iff (!rst_n) sleep_go |=> !pd_q ##1 rd_en || !pd_q || $past(wr_status);
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("Power-down flag not cleared.");

   property p_to_set;
      @(posedge clock) disable iff (!rst_n) sleep_go |=> to_q;
   endproperty
   a_to_set: assert property (p_to_set) else $error("Timeout flag not set.");

   property p_clk_stop;
      @(posedge clock) disable iff (!rst_n) mode_q == SMEC_SLEEP |-> !cpu_clk_en_q && !sys_clk_en_q;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("Clock running in sleep.");

   property p_osc_run;
      @(posedge clock) disable iff (!rst_n)
         asleep |-> low_freq_internal_osc_en_q && high_freq_internal_osc_en_q && secondary_osc_en_q;
   endproperty
   a_osc_run: assert property (p_osc_run) else $error("Oscillator stopped in sleep.");

   property p_adc;
      @(posedge clock) disable iff (!rst_n) full_go && adc_busy |=> adc_abort_q == !$past(adc_rc_sel) ##1 !adc_abort_q;
   endproperty
   a_adc: assert property (p_adc) else $error("Conversion handling wrong at sleep.");

   property p_io_hold;
      @(posedge clock) disable iff (!rst_n)
         asleep && $past(asleep) |-> ((io_out_q ^ $past(io_out_q)) & ~$past(async_io_en)) == '0;
   endproperty
   a_io_hold: assert property (p_io_hold) else $error("Pin changed during sleep.");

   property p_ext_reset;
      @(posedge clock) disable iff (!rst_n) asleep && rst_s_q[1] |=> ext_reset_req_q;
   endproperty
   a_ext_reset: assert property (p_ext_reset) else $error("Reset lost in sleep.");

   c_full:   cover property (@(posedge clock) disable iff (!rst_n) full_go ##[1:50] mode_q == SMEC_RUN);
   c_idle:   cover property (@(posedge clock) disable iff (!rst_n) sleep_go && idle_select_bit);
   c_abort:  cover property (@(posedge clock) disable iff (!rst_n) abandon);
   c_wdt_to: cover property (@(posedge clock) disable iff (!rst_n) asleep && wif.timeout);
endmodule

// [sim/smec_core_model.sv]
// Processor core model that issues sleep instructions and drives pin values.
`timescale 1ns/1ps
module smec_core_model #(
   parameter int IO_W = 8
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              cpu_clk_en,
   input  wire logic              sleep_req,
   input  wire logic [2*IO_W-1:0] rnd,
   output logic                   sleep_exec,
   output logic [IO_W-1:0]        io_out,
   output logic [IO_W-1:0]        io_oe
);
   // ---------------------------------------------------------------
   // Core behaviour
   // ---------------------------------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sleep_exec <= 1'b0;
         io_out     <= '0;
         io_oe      <= '0;
      end else begin
         sleep_exec <= sleep_req & cpu_clk_en;
         // A halted core holds nothing, so its pin values keep changing.
         if (!cpu_clk_en) begin
            io_out <= ~io_out;
            io_oe  <= ~io_oe;
         end else if (!sleep_req && !sleep_exec) begin
            io_out <= rnd[IO_W-1:0];
            io_oe  <= rnd[2*IO_W-1:IO_W];
         end
      end
   end
endmodule

// [sim/tb_sleep_mode_entry_control.sv]
// Self-checking bench for the sleep and idle entry controller.
`timescale 1ns/1ps
module tb_sleep_mode_entry_control
   import smec_pkg::*;
;
   localparam int PER = 16;
   logic clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, sleep_req = 1'b0;
   logic wake_pin = 1'b0, ext_reset_pin = 1'b0, adc_busy = 1'b0, sleep_exec;
   logic [3:0] addr = '0;
   logic [7:0] wdata = '0, async_io_en = '0, async_io_out = '0, core_io_out, core_io_oe, rdata_q, io_out_q, io_oe_q;
   logic cpu_clk_en_q, sys_clk_en_q, lfo_q, hfo_q, so_q, adc_abort_q, wdt_reset_q, ext_reset_req_q;
   smec_mode_t mode_q;
   logic [31:0] seed = 32'h6C785333;
   int error_cnt = 0, num_checks = 0, wdt_hits = 0, i, n;

   smec_top #(.IO_W(8), .WDT_PERIOD(PER)) smec_top_i (.clock(clock), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q), .sleep_exec(sleep_exec),
      .wake_pin(wake_pin), .ext_reset_pin(ext_reset_pin), .adc_busy(adc_busy), .core_io_out(core_io_out),
      .core_io_oe(core_io_oe), .async_io_en(async_io_en), .async_io_out(async_io_out), .io_out_q(io_out_q),
      .io_oe_q(io_oe_q), .cpu_clk_en_q(cpu_clk_en_q), .sys_clk_en_q(sys_clk_en_q),
      .low_freq_internal_osc_en_q(lfo_q), .high_freq_internal_osc_en_q(hfo_q), .secondary_osc_en_q(so_q),
      .adc_abort_q(adc_abort_q), .wdt_reset_q(wdt_reset_q), .ext_reset_req_q(ext_reset_req_q), .mode_q(mode_q));
   smec_core_model #(.IO_W(8)) smec_core_model_i (.clock(clock), .rst_n(rst_n), .cpu_clk_en(cpu_clk_en_q),
      .sleep_req(sleep_req), .rnd(seed[15:0]), .sleep_exec(sleep_exec), .io_out(core_io_out), .io_oe(core_io_oe));

   always #25 clock = ~clock;
   always @(posedge clock) begin
      seed <= xs(seed);
      if (wdt_reset_q === 1'b1) wdt_hits++;
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string msg);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      @(negedge clock);
      chk(rdata_q, exp, msg);
   endtask
   // Pulses the sleep request; the design takes it at the edge after this returns.
   task automatic enter();
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      @(negedge clock);
   endtask
   task automatic wake();
      @(posedge clock);
      wake_pin <= 1'b1;
      for (i = 0; i < 8 && mode_q !== SMEC_RUN; i++) @(negedge clock);
      chk({mode_q, cpu_clk_en_q, sys_clk_en_q}, 4'h3, "wake");
      @(posedge clock);
      wake_pin <= 1'b0;
   endtask
   task automatic sleep_cycle(input logic [3:0] ctrl, input logic busy);
      logic [7:0] ho, he, aen, aout;
      logic full, ab;
      full = ~ctrl[SMEC_CTRL_IDLE];
      ab = full & busy & ~ctrl[SMEC_CTRL_ADCRC];
      aen = seed[7:0];
      aout = seed[15:8];
      wr(SMEC_OFS_CTRL, {4'h0, ctrl});
      wr(SMEC_OFS_STATUS, 8'h05);
      adc_busy <= busy;
      async_io_en <= aen;
      async_io_out <= aout;
      enter();
      // The core stops updating its pins once it sees the request, so these are the pre-sleep values.
      ho = core_io_out;
      he = core_io_oe;
      @(negedge clock);
      chk({6'h0, mode_q}, {6'h0, full ? SMEC_SLEEP : SMEC_IDLE}, "mode");
      chk({cpu_clk_en_q, sys_clk_en_q, lfo_q, hfo_q, so_q, adc_abort_q}, {1'b0, ~full, 3'b111, ab}, "clk");
      @(negedge clock);
      chk(adc_abort_q, 1'b0, "abort pulse");
      repeat (3) @(negedge clock);
      chk(io_out_q, (ho & ~aen) | (aout & aen), "pin out");
      chk(io_oe_q, he | aen, "pin oe");
      @(posedge clock);
      ext_reset_pin <= 1'b1;
      for (i = 0; i < 6 && ext_reset_req_q !== 1'b1; i++) @(negedge clock);
      chk(ext_reset_req_q, 1'b1, "ext reset asleep");
      @(posedge clock);
      ext_reset_pin <= 1'b0;
      for (i = 0; i < 6 && ext_reset_req_q !== 1'b0; i++) @(negedge clock);
      wake();
      rdchk(SMEC_OFS_STATUS, {5'h0, ab, 2'b10}, "status after entry");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      rdchk(SMEC_OFS_STATUS, 8'h03, "status reset");
      rdchk(SMEC_OFS_CTRL, 8'h00, "ctrl reset");
      wr(4'h9, 8'hFF);
      rdchk(4'h9, 8'h00, "unmapped");
      wr(SMEC_OFS_CTRL, 8'h0A);
      rdchk(SMEC_OFS_CTRL, 8'h0A, "ctrl rw");
      wr(SMEC_OFS_CTRL, 8'h04);
      repeat (20) @(negedge clock);
      rdchk(SMEC_OFS_STATUS, 8'h01, "wrap clears timeout");
      $display("test registers done");
      // Watchdog stays off here so the timeout flag is only moved by entry.
      for (n = 0; n < 10; n++) begin
         if (n < 6) sleep_cycle(n[0] ? (n[1] ? 4'h9 : 4'h1) : (n[1] ? 4'h8 : 4'h0), n != 4);
         else sleep_cycle(seed[19:16] & 4'hB, seed[20]);
      end
      $display("test entry done");
      wr(SMEC_OFS_CTRL, 8'h06);
      // Let the count grow first, so an uncleared counter would wrap well before the first check.
      repeat (8) @(posedge clock);
      enter();
      n = wdt_hits;
      repeat (14) @(negedge clock);
      chk(wdt_hits - n, 8'h00, "watchdog cleared");
      repeat (6) @(negedge clock);
      chk(wdt_hits - n, 8'h01, "watchdog runs asleep");
      wake();
      wr(SMEC_OFS_CTRL, 8'h04);
      enter();
      n = wdt_hits;
      rdchk(SMEC_OFS_WDT_LO, 8'h00, "count low cleared");
      rdchk(SMEC_OFS_WDT_HI, 8'h00, "count high cleared");
      repeat (24) @(negedge clock);
      chk(wdt_hits - n, 8'h00, "watchdog halted");
      rdchk(SMEC_OFS_WDT_LO, 8'h00, "count frozen");
      wake();
      wr(SMEC_OFS_CTRL, 8'h00);
      $display("test watchdog done");
      final_report();
   end
   initial begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      final_report();
   end
endmodule
